// ---- common/dsr_pkg.sv ----
package dsr_pkg;

  // Geometry
  localparam int NUM_CH      = 8;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 16;

  // Register offsets (word index on the plain port)
  localparam logic [3:0] COLL_OFS   = 4'h0;
  localparam logic [3:0] ACT_OFS    = 4'h1;
  localparam logic [3:0] RADDR_OFS  = 4'h2;
  localparam logic [3:0] IRQ_ST_OFS = 4'h3;
  localparam logic [3:0] IRQ_MK_OFS = 4'h4;
  localparam logic [3:0] PPMODE_OFS = 4'h5;

  // Field positions
  localparam int PERIPH_COL_LSB = 8;
  localparam int RAM_COL_LSB    = 0;
  localparam int LAST_CH_LSB    = 8;
  localparam int PINGPONG_BUFFER_STATUS_LSB       = 0;

  // Reset values
  localparam logic [15:0] COLL_RST    = 16'h0000;
  localparam logic [3:0]  LAST_CH_RST = 4'hf;
  localparam logic [7:0]  PINGPONG_BUFFER_STATUS_RST    = 8'h00;
  localparam logic [15:0] RADDR_RST   = 16'h0000;
  localparam logic [2:0]  IRQ_RST     = 3'h0;
  localparam logic [7:0]  PPMODE_RST  = 8'h00;

  // Interrupt status bit positions
  localparam int IRQ_PCOL_BIT = 0;
  localparam int IRQ_RCOL_BIT = 1;
  localparam int IRQ_XFER_BIT = 2;

  // One transfer report from the channel engine
  typedef struct packed {
    logic        valid;
    logic [2:0]  channel;
    logic [15:0] ram_addr;
  } dsr_xfer_type;

  // Software register port
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dsr_bus_type;

endpackage

// ---- design/dsr_status.sv ----
// Function
// - Peripheral collision flags, bits 15..8, reset low, cleared by software.
// - RAM collision flags, bits 7..0, reset low, cleared by software.
// - Last channel field reads 1111 after reset, then the latest channel.
// - Ping-pong bit per channel, reset 0, reads 1 while secondary is in use.
// - Read-only 16-bit most recent RAM address of any channel, reset 0.
// - In ping-pong modes a channel alternates buffers block by block.
`timescale 1ns/10ps
`default_nettype none

module dsr_status
#(
  parameter int NUM_CH = dsr_pkg::NUM_CH
)
(
  input  wire logic                   clk,           // System clock
  input  wire logic                   rst,           // Sync reset, high
  input  wire dsr_pkg::dsr_bus_type  bus,           // Register port
  output logic [15:0]                 rdata,         // Read data, next cycle
  input  wire logic [NUM_CH-1:0]      periph_col,    // Peripheral collision
  input  wire logic [NUM_CH-1:0]      ram_col,       // RAM collision
  input  wire dsr_pkg::dsr_xfer_type xfer,          // Transfer report
  input  wire logic [NUM_CH-1:0]      block_done,    // Block complete
  output logic [NUM_CH-1:0]           secondary_sel, // Buffer select out
  output logic                        irq            // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  // Software-visible status
  logic [NUM_CH-1:0] periph_write_collision_flag_r;
  logic [NUM_CH-1:0] ram_write_collision_flag_r;
  logic [3:0]        last_active_channel_r;
  logic [NUM_CH-1:0] pingpong_buffer_status_r;
  logic [15:0]       recent_ram_address_r;
  // Control and interrupt state
  logic [NUM_CH-1:0] pingpong_mode_r;
  logic [2:0]        irq_status_r;
  logic [2:0]        irq_mask_r;
  // Read path and decode helpers
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;
  logic [2:0]        irq_event;
  logic [15:0]       coll_word;
  logic [15:0]       act_word;
  logic              coll_wr;
  logic [NUM_CH-1:0] periph_clr;
  logic [NUM_CH-1:0] ram_clr;

  // Address match for the write decodes and the clear-on-read strobe
  // Kept in one place so every decode compares the full index
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Clear masks: writing a one clears, zeros leave the flag alone
  assign coll_wr    = bus.wr && hit(bus.addr, dsr_pkg::COLL_OFS);
  assign periph_clr = coll_wr
                      ? bus.wdata[dsr_pkg::PERIPH_COL_LSB +: NUM_CH]
                      : '0;
  assign ram_clr    = coll_wr
                      ? bus.wdata[dsr_pkg::RAM_COL_LSB +: NUM_CH]
                      : '0;

  // Per-channel state: two collision flags and the buffer select.
  // A hit in the clearing cycle wins, so software never loses a
  // collision that it has not read yet.
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chan
    // Peripheral side collision flag
    always_ff @(posedge clk)
    begin
      if (rst)
        periph_write_collision_flag_r[ch] <=
          dsr_pkg::COLL_RST[dsr_pkg::PERIPH_COL_LSB + ch];
      else if (periph_col[ch])
        periph_write_collision_flag_r[ch] <= 1'b1;
      else if (periph_clr[ch])
        periph_write_collision_flag_r[ch] <= 1'b0;
    end

    // Same scheme for the RAM side flag
    always_ff @(posedge clk)
    begin
      if (rst)
        ram_write_collision_flag_r[ch] <=
          dsr_pkg::COLL_RST[dsr_pkg::RAM_COL_LSB + ch];
      else if (ram_col[ch])
        ram_write_collision_flag_r[ch] <= 1'b1;
      else if (ram_clr[ch])
        ram_write_collision_flag_r[ch] <= 1'b0;
    end

    // Toggle only at a block end of a channel in ping-pong mode;
    // the engine must not start the next block before this edge
    always_ff @(posedge clk)
    begin
      if (rst)
        pingpong_buffer_status_r[ch] <= dsr_pkg::PINGPONG_BUFFER_STATUS_RST[ch];
      else if (block_done[ch] && pingpong_mode_r[ch])
        pingpong_buffer_status_r[ch] <=
          ~pingpong_buffer_status_r[ch];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Last channel and most recent RAM address
  // Bit 3 is forced low on update, so reserved codes never appear
  // and all ones keeps meaning no transfer since reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_active_channel_r <= dsr_pkg::LAST_CH_RST;
      recent_ram_address_r  <= dsr_pkg::RADDR_RST;
    end
    else if (xfer.valid)
    begin
      last_active_channel_r <= {1'b0, xfer.channel};
      recent_ram_address_r  <= xfer.ram_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ping-pong mode enables, written by the channel setup software
  // Reset leaves every channel out of ping-pong mode
  always_ff @(posedge clk)
  begin
    if (rst)
      pingpong_mode_r <= NUM_CH'(dsr_pkg::PPMODE_RST);
    else if (bus.wr && hit(bus.addr, dsr_pkg::PPMODE_OFS))
      pingpong_mode_r <= bus.wdata[NUM_CH-1:0];
  end

  // Buffer select goes straight out to the channel engine
  assign secondary_sel = pingpong_buffer_status_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by reading; new events win
  assign irq_event[dsr_pkg::IRQ_PCOL_BIT] = |periph_col;
  assign irq_event[dsr_pkg::IRQ_RCOL_BIT] = |ram_col;
  assign irq_event[dsr_pkg::IRQ_XFER_BIT] = xfer.valid;

  // A status read that meets a new event keeps that event pending;
  // the read itself shows only what was pending before it
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_status_r <= dsr_pkg::IRQ_RST;
    else if (bus.rd && hit(bus.addr, dsr_pkg::IRQ_ST_OFS))
      irq_status_r <= irq_event;
    else
      irq_status_r <= irq_status_r | irq_event;
  end

  // Mask bits line up with the status bits
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask_r <= dsr_pkg::IRQ_RST;
    else if (bus.wr && hit(bus.addr, dsr_pkg::IRQ_MK_OFS))
      irq_mask_r <= bus.wdata[2:0];
  end

  // Level output; drops only on a status read or a mask change
  assign irq = |(irq_status_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses return zero
  // Collision word built from the field positions
  always_comb
  begin
    coll_word = 16'h0000;
    coll_word[dsr_pkg::PERIPH_COL_LSB +: NUM_CH] =
      periph_write_collision_flag_r;
    coll_word[dsr_pkg::RAM_COL_LSB +: NUM_CH] =
      ram_write_collision_flag_r;
  end

  // Activity word; the upper nibble is unused and reads zero
  always_comb
  begin
    act_word = 16'h0000;
    act_word[dsr_pkg::LAST_CH_LSB +: 4] = last_active_channel_r;
    act_word[dsr_pkg::PINGPONG_BUFFER_STATUS_LSB +: NUM_CH] =
      pingpong_buffer_status_r;
  end

  // Answer for the cycle after the strobe; zero when idle so that a
  // stale word never looks like a fresh answer
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        dsr_pkg::COLL_OFS:   rdata_nxt = coll_word;
        dsr_pkg::ACT_OFS:    rdata_nxt = act_word;
        dsr_pkg::RADDR_OFS:  rdata_nxt = recent_ram_address_r;
        dsr_pkg::IRQ_ST_OFS: rdata_nxt = {13'h0, irq_status_r};
        dsr_pkg::IRQ_MK_OFS: rdata_nxt = {13'h0, irq_mask_r};
        dsr_pkg::PPMODE_OFS: rdata_nxt[NUM_CH-1:0] = pingpong_mode_r;
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Registered so the answer stands for exactly one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata = rdata_r;

endmodule

`default_nettype wire

// ---- tb/dsr_status_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsr_status_chk
#(
  parameter int NUM_CH = 8
)
(
  input wire logic                  clk,           // Clock
  input wire logic                  rst,           // Sync reset
  input wire dsr_pkg::dsr_bus_type  bus,           // Register port
  input wire logic [15:0]           rdata,         // Read data
  input wire logic [NUM_CH-1:0]     periph_col,    // Periph hits
  input wire logic [NUM_CH-1:0]     ram_col,       // RAM hits
  input wire dsr_pkg::dsr_xfer_type xfer,          // Transfer
  input wire logic [NUM_CH-1:0]     block_done,    // Block done
  input wire logic [NUM_CH-1:0]     secondary_sel, // Buffer select
  input wire logic                  irq            // Interrupt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Read strobes per register
  logic rd_c;
  logic rd_a;
  logic rd_r;
  assign rd_c = bus.rd && bus.addr == dsr_pkg::COLL_OFS;
  assign rd_a = bus.rd && bus.addr == dsr_pkg::ACT_OFS;
  assign rd_r = bus.rd && bus.addr == dsr_pkg::RADDR_OFS;
  ////////////////////////////////////////////////////////////////////////
  // No write between hit and read, so the flag must still show
  a_periph_flag_set: assert property (
    periph_col != '0 ##1 !bus.wr ##1 rd_c
    |=> (rdata[15:8] & $past(periph_col, 3)) == $past(periph_col, 3))
    else $error("periph flag missing");
  a_ram_flag_set: assert property (ram_col != '0 ##1 !bus.wr ##1 rd_c
    |=> (rdata[7:0] & $past(ram_col, 3)) == $past(ram_col, 3))
    else $error("ram flag missing");
  a_last_chan: assert property (xfer.valid ##1 !xfer.valid ##1 rd_a
    |=> rdata[11:8] == {1'b0, $past(xfer.channel, 3)})
    else $error("last channel wrong");
  a_no_reserved: assert property (rd_a |=> rdata[15:12] == 4'h0
    && !(rdata[11] && rdata[10:8] != 3'h7))
    else $error("reserved code read");
  a_ram_addr: assert property (xfer.valid ##1 !xfer.valid ##1 rd_r
    |=> rdata == $past(xfer.ram_addr, 3))
    else $error("ram address wrong");
  a_pp_visible: assert property (
    rd_a |=> rdata[7:0] == $past(secondary_sel))
    else $error("buffer status mismatch");
  // A buffer swap is only legal at a block end
  a_pp_toggle: assert property (
    ((secondary_sel ^ $past(secondary_sel)) & ~$past(block_done)) == '0)
    else $error("buffer swap without block end");
  c_xfer: cover property (xfer.valid ##2 rd_a);
  c_swap: cover property (block_done != '0 ##1 secondary_sel != '0);
  c_irq: cover property ($rose(irq));
endmodule
bind dsr_status dsr_status_chk #(.NUM_CH(NUM_CH)) u_chk (.clk, .rst, .bus,
  .rdata, .periph_col, .ram_col, .xfer, .block_done, .secondary_sel, .irq);
`default_nettype wire

// ---- tb/dsr_status_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsr_status_bench;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  dsr_pkg::dsr_bus_type  bus = '0;
  dsr_pkg::dsr_xfer_type xfer = '0;
  logic [7:0]            pc = 8'h00;
  logic [7:0]            rc = 8'h00;
  logic [7:0]            bd = 8'h00;
  logic [15:0]           rdata;
  logic [7:0]            sel;
  logic                  irq;
  logic [15:0]           d;
  int                    n_errors = 0;
  int                    n_compared = 0;
  int                    cycles = 0;
  always #4 clk = ~clk;
  dsr_status u_dsr_status
  (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .periph_col(pc),
    .ram_col(rc), .xfer(xfer), .block_done(bd), .secondary_sel(sel),
    .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One bus cycle; read data captured after the edge lands
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{a, v, w, !w};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic ev(input logic [7:0] p, r, b, input logic v,
                    input logic [2:0] c, input logic [15:0] a);
    @(posedge clk);
    {pc, rc, bd} <= {p, r, b};
    xfer <= '{v, c, a};
    @(posedge clk);
    {pc, rc, bd} <= 24'h000000;
    xfer <= '0;
    #1;
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    acc(0, dsr_pkg::COLL_OFS, 0); chk("coll", 16'h0000, d);
    acc(0, dsr_pkg::ACT_OFS, 0); chk("act", 16'h0f00, d);
    acc(0, dsr_pkg::RADDR_OFS, 0); chk("raddr", 16'h0000, d);
    $display("t_reset done");
  endtask
  // Masked first, then unmasked; the first clear is partial on purpose, the second clears the rest
  task automatic t_coll;
    ev(8'h81, 8'h24, 0, 0, 0, 0);
    acc(0, 0, 0); chk("coll", 16'h8124, d);
    chk("irq", 16'h0000, {15'h0, irq});
    acc(1, dsr_pkg::IRQ_MK_OFS, 16'h0003); chk("irq", 16'h0001, {15'h0, irq});
    acc(0, dsr_pkg::IRQ_ST_OFS, 0); chk("ist", 16'h0003, d);
    chk("irq", 16'h0000, {15'h0, irq});
    acc(1, 0, 16'h8004); acc(0, 0, 0); chk("coll", 16'h0120, d);
    acc(1, dsr_pkg::ACT_OFS, 16'hffff);
    acc(0, dsr_pkg::ACT_OFS, 0); chk("act", 16'h0f00, d);
    acc(1, 0, 16'h0124); acc(0, 0, 0); chk("coll", 16'h0000, d);
    acc(0, 4'hf, 0); chk("unmapped", 16'h0000, d);
    $display("t_coll done");
  endtask
  task automatic t_xfer;
    for (int c = 0; c < 8; c++)
    begin
      ev(0, 0, 0, 1, c[2:0], 16'h1a00 + c[15:0]);
      acc(0, dsr_pkg::ACT_OFS, 0); chk("act", {5'h0, c[2:0], 8'h00}, d);
      acc(0, dsr_pkg::RADDR_OFS, 0); chk("raddr", 16'h1a00 + c[15:0], d);
    end
    ev(0, 0, 0, 1, 3'h5, 16'hbeef);
    acc(0, dsr_pkg::RADDR_OFS, 0); chk("raddr", 16'hbeef, d);
    acc(0, dsr_pkg::IRQ_ST_OFS, 0); chk("ist", 16'h0004, d);
    $display("t_xfer done");
  endtask
  // Only channels 0 and 2 run in ping-pong mode
  task automatic t_pp;
    acc(1, dsr_pkg::PPMODE_OFS, 16'h0005);
    ev(0, 0, 8'h0f, 0, 0, 0); chk("sel", 16'h0005, {8'h00, sel});
    acc(0, dsr_pkg::ACT_OFS, 0); chk("act", 16'h0505, d);
    ev(0, 0, 8'h05, 0, 0, 0); chk("sel", 16'h0000, {8'h00, sel});
    ev(0, 0, 8'h81, 0, 0, 0); chk("sel", 16'h0001, {8'h00, sel});
    $display("t_pp done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_coll;
    t_xfer;
    t_pp;
    finish_test;
  end
endmodule
`default_nettype wire
